/* File: hdl/stc_top.sv */
// Summary of operation
// - types 2/3 panel trigger; 3 adds settling
// - local rate key press starts one measurement in types 2/3
// - type 1 triggers continuously from rate tick
// - types 4/5: rear trigger or trigger command, not rate key
// - trigger command fires in types 2 to 5
// - trigger-config command applies type and settings
// - rates 2.5, 20, 100 per second
// - event bits sticky until read or clear
// - enabled event rising sets event summary bit
// - event read or clear drops summary bit
// - operation complete once prior commands finish
// - query error on three buffer conditions
// - device error on calibration or overflow
// - execution error on unexecutable command
// - command error on unparsable command
// - power-on bit set after power cycle
// - message available: placed sets, terminator clears
// - master summary from masked status bits
// - service flag set, serial poll clears it
// - status query returns byte, changes nothing
// - mask value over 255: no write, error
// - event query returns value then clears
// - clear-status clears events; first clears message
`timescale 1ns/1ps
`include "stc_regs.svh"

module stc_top
    import stc_pkg::*;
#(
    parameter int unsigned SLOW_CYC   = `STC_PERIOD_CYC(`STC_RATE_SLOW_DHZ),
    parameter int unsigned MED_CYC    = `STC_PERIOD_CYC(`STC_RATE_MED_DHZ),
    parameter int unsigned FAST_CYC   = `STC_PERIOD_CYC(`STC_RATE_FAST_DHZ),
    parameter int unsigned SETTLE_CYC = `STC_SETTLE_CYC
)
(
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    // register commands
    input  wire logic        CLEAR_STATUS_I,
    input  wire logic        CLEAR_FIRST_I,
    input  wire logic        EVENT_MASK_WR_I,
    input  wire logic        SERVICE_MASK_WR_I,
    input  wire logic [15:0] CMD_VALUE_I,
    input  wire logic        EVENT_STATUS_RD_I,
    input  wire logic        EVENT_MASK_RD_I,
    input  wire logic        SERVICE_MASK_RD_I,
    input  wire logic        STATUS_BYTE_RD_I,
    input  wire logic        SERIAL_POLL_I,
    input  wire logic        OP_COMPLETE_CMD_I,
    input  wire logic        CMD_BUSY_I,
    // trigger commands
    input  wire logic        TRIGGER_CMD_I,
    input  wire logic        TRIG_CFG_I,
    input  wire logic [2:0]  TRIG_CFG_TYPE_I,
    // event sources
    input  wire logic        QUERY_EMPTY_READ_I,
    input  wire logic        QUERY_UNREAD_I,
    input  wire logic        BUFFERS_FULL_I,
    input  wire logic        CAL_INPUT_ERR_I,
    input  wire logic        INPUT_OVERFLOW_I,
    input  wire logic        EXEC_ERR_I,
    input  wire logic        CMD_ERR_I,
    input  wire logic        MSG_PLACED_I,
    input  wire logic        TERM_SENT_I,
    // front and rear panel
    input  wire logic        REMOTE_I,
    input  wire logic        RATE_KEY_I,
    input  wire logic        PANEL_SEL_I,
    input  wire logic [2:0]  PANEL_TYPE_I,
    input  wire logic        REAR_TRIG_I,
    input  wire logic        PANEL_SERVICE_I,
    input  wire logic [1:0]  RATE_SEL_I,
    // responses and status
    output logic [7:0]       RESP_DATA_O,
    output logic             RESP_VALID_O,
    output logic [7:0]       STATUS_BYTE_O,
    output logic [7:0]       EVENT_STATUS_O,
    output logic             REQ_SERVICE_O,
    // trigger outputs
    output logic [2:0]       TRIG_TYPE_O,
    output logic             EXT_TRIG_O,
    output logic             SETTLING_O,
    output logic             MEAS_START_O
);

    // ==================================================
    // helpers
    function automatic logic is_ext(input stc_trig_t t);
        is_ext = (t >= `STC_TT_PANEL) && (t <= `STC_TT_REAR_SETTLE);
    endfunction

    function automatic logic has_settle(input stc_trig_t t);
        has_settle = (t == `STC_TT_PANEL_SETTLE) || (t == `STC_TT_REAR_SETTLE);
    endfunction

    function automatic logic value_ok(input logic [15:0] v);
        value_ok = (v <= `STC_VALUE_MAX);
    endfunction

    function automatic logic type_ok(input stc_trig_t t);
        type_ok = (t == `STC_TT_INTERNAL) || is_ext(t);
    endfunction

    // ==================================================
    // status state
    stc_byte_t event_status_q;
    stc_byte_t event_status_d;
    stc_byte_t event_enable_mask_q;
    stc_byte_t event_enable_mask_d;
    stc_byte_t service_request_mask_q;
    stc_byte_t service_request_mask_d;
    stc_byte_t summary_status_byte_q;
    stc_byte_t summary_status_byte_d;
    logic      event_summary_bit_q;
    logic      event_summary_bit_d;
    logic      message_available_bit_q;
    logic      message_available_bit_d;
    logic      request_service_flag_q;
    logic      request_service_flag_d;
    logic      op_pend_q;
    logic      op_pend_d;
    stc_byte_t resp_d;
    logic      resp_valid_d;
    stc_byte_t ev_set;
    stc_byte_t ev_base;
    logic      ev_clr;
    logic      mask_bad;
    logic      cfg_bad;
    logic      op_fire;

    // ==================================================
    // trigger state
    stc_trig_t trig_type_q;
    stc_trig_t trig_type_d;
    logic      key_q;
    logic      rear_q;
    logic      rear_pend_q;
    logic      rear_pend_d;
    logic      meas_d;
    logic      fire;
    logic      settle_start;
    logic      rate_tick;
    logic      settle_busy;
    logic      settle_done;

    // ==================================================
    // status next state
    always_comb
    begin
        mask_bad = (EVENT_MASK_WR_I | SERVICE_MASK_WR_I) & ~value_ok(CMD_VALUE_I);
        cfg_bad  = TRIG_CFG_I & ~type_ok(TRIG_CFG_TYPE_I);
        ev_clr   = EVENT_STATUS_RD_I | CLEAR_STATUS_I;

        op_pend_d = (op_pend_q | OP_COMPLETE_CMD_I);
        op_fire   = op_pend_d & ~CMD_BUSY_I;
        if (op_fire)
            op_pend_d = 1'b0;

        ev_set = 8'h00;
        ev_set[`STC_EV_OP_DONE]   = op_fire;
        ev_set[`STC_EV_QUERY_ERR] = QUERY_EMPTY_READ_I | QUERY_UNREAD_I | BUFFERS_FULL_I;
        ev_set[`STC_EV_DEV_ERR]   = CAL_INPUT_ERR_I | INPUT_OVERFLOW_I;
        ev_set[`STC_EV_EXEC_ERR]  = EXEC_ERR_I | mask_bad | cfg_bad;
        ev_set[`STC_EV_CMD_ERR]   = CMD_ERR_I;

        // a set in the clearing cycle survives
        ev_base        = ev_clr ? 8'h00 : event_status_q;
        event_status_d = (ev_base | ev_set) & `STC_EV_USED;

        event_summary_bit_d = (event_summary_bit_q & ~ev_clr)
                            | (|(ev_set & ~ev_base & event_enable_mask_q));

        message_available_bit_d = MSG_PLACED_I
                                | (message_available_bit_q & ~TERM_SENT_I
                                   & ~(CLEAR_STATUS_I & CLEAR_FIRST_I));

        event_enable_mask_d = event_enable_mask_q;
        if (EVENT_MASK_WR_I && value_ok(CMD_VALUE_I))
            event_enable_mask_d = CMD_VALUE_I[7:0];
        service_request_mask_d = service_request_mask_q;
        if (SERVICE_MASK_WR_I && value_ok(CMD_VALUE_I))
            service_request_mask_d = CMD_VALUE_I[7:0] & `STC_SVC_STORE;

        summary_status_byte_d = 8'h00;
        summary_status_byte_d[`STC_SB_MSG_AVAIL] = message_available_bit_d;
        summary_status_byte_d[`STC_SB_EVENT_SUM] = event_summary_bit_d;
        summary_status_byte_d[`STC_SB_MASTER_SUM] =
            |(summary_status_byte_d & service_request_mask_d & `STC_SVC_USED);

        request_service_flag_d = PANEL_SERVICE_I
                               | summary_status_byte_d[`STC_SB_MASTER_SUM]
                               | (request_service_flag_q & ~SERIAL_POLL_I);

        // one query answered per cycle
        resp_valid_d = 1'b1;
        resp_d       = 8'h00;
        if (EVENT_STATUS_RD_I)
            resp_d = event_status_q;
        else if (EVENT_MASK_RD_I)
            resp_d = event_enable_mask_q;
        else if (SERVICE_MASK_RD_I)
            resp_d = service_request_mask_q;
        else if (STATUS_BYTE_RD_I)
            resp_d = summary_status_byte_q;
        else if (SERIAL_POLL_I)
        begin
            resp_d = summary_status_byte_q;
            resp_d[`STC_SB_MASTER_SUM] = request_service_flag_q;
        end
        else
            resp_valid_d = 1'b0;
    end

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            event_status_q          <= `STC_EV_RESET;
            event_enable_mask_q     <= `STC_MASK_RESET;
            service_request_mask_q  <= `STC_MASK_RESET;
            summary_status_byte_q   <= 8'h00;
            event_summary_bit_q     <= 1'b0;
            message_available_bit_q <= 1'b0;
            request_service_flag_q  <= 1'b0;
            op_pend_q               <= 1'b0;
            RESP_DATA_O             <= 8'h00;
            RESP_VALID_O            <= 1'b0;
        end
        else
        begin
            event_status_q          <= event_status_d;
            event_enable_mask_q     <= event_enable_mask_d;
            service_request_mask_q  <= service_request_mask_d;
            summary_status_byte_q   <= summary_status_byte_d;
            event_summary_bit_q     <= event_summary_bit_d;
            message_available_bit_q <= message_available_bit_d;
            request_service_flag_q  <= request_service_flag_d;
            op_pend_q               <= op_pend_d;
            RESP_DATA_O             <= resp_d;
            RESP_VALID_O            <= resp_valid_d;
        end
    end

    assign STATUS_BYTE_O  = summary_status_byte_q;
    assign EVENT_STATUS_O = event_status_q;
    assign REQ_SERVICE_O  = request_service_flag_q;

    // ==================================================
    // rate divider and settling timer
    stc_rate_div #(
        .SLOW_CYC (SLOW_CYC),
        .MED_CYC  (MED_CYC),
        .FAST_CYC (FAST_CYC)
    ) u_rate (
        .clk_i    (CLOCK_I),
        .rst_i    (RST_I),
        .rate_i   (stc_rate_t'(RATE_SEL_I)),
        .tick_o   (rate_tick)
    );

    stc_settle #(
        .DELAY_CYC (SETTLE_CYC)
    ) u_settle (
        .clk_i     (CLOCK_I),
        .rst_i     (RST_I),
        .start_i   (settle_start),
        .busy_o    (settle_busy),
        .done_o    (settle_done)
    );

    // ==================================================
    // trigger next state
    always_comb
    begin
        trig_type_d = trig_type_q;
        if (TRIG_CFG_I && type_ok(TRIG_CFG_TYPE_I))
            trig_type_d = TRIG_CFG_TYPE_I;
        else if (PANEL_SEL_I && type_ok(PANEL_TYPE_I))
            trig_type_d = PANEL_TYPE_I;

        rear_pend_d = rear_pend_q;
        if (REAR_TRIG_I && !rear_q
            && (trig_type_q == `STC_TT_REAR || trig_type_q == `STC_TT_REAR_SETTLE))
            rear_pend_d = 1'b1;

        fire = 1'b0;
        if (rate_tick && trig_type_q == `STC_TT_INTERNAL)
            fire = 1'b1;
        if (rate_tick && rear_pend_q)
        begin
            fire        = 1'b1;
            rear_pend_d = 1'b0;
        end
        if (RATE_KEY_I && !key_q && !REMOTE_I
            && (trig_type_q == `STC_TT_PANEL || trig_type_q == `STC_TT_PANEL_SETTLE))
            fire = 1'b1;
        if (TRIGGER_CMD_I && is_ext(trig_type_q))
            fire = 1'b1;
        // leaving a rear type drops a waiting rear trigger
        if (!(trig_type_d == `STC_TT_REAR || trig_type_d == `STC_TT_REAR_SETTLE))
            rear_pend_d = 1'b0;

        settle_start = fire & has_settle(trig_type_q) & ~settle_busy;
        meas_d       = (fire & ~has_settle(trig_type_q)) | settle_done;
    end

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            trig_type_q  <= `STC_TT_INTERNAL;
            key_q        <= 1'b0;
            rear_q       <= 1'b0;
            rear_pend_q  <= 1'b0;
            TRIG_TYPE_O  <= `STC_TT_INTERNAL;
            EXT_TRIG_O   <= 1'b0;
            SETTLING_O   <= 1'b0;
            MEAS_START_O <= 1'b0;
        end
        else
        begin
            trig_type_q  <= trig_type_d;
            key_q        <= RATE_KEY_I;
            rear_q       <= REAR_TRIG_I;
            rear_pend_q  <= rear_pend_d;
            TRIG_TYPE_O  <= trig_type_d;
            EXT_TRIG_O   <= is_ext(trig_type_d);
            SETTLING_O   <= has_settle(trig_type_d);
            MEAS_START_O <= meas_d;
        end
    end

endmodule

/* File: hdl/stc_regs.svh */
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// ==================================================
// timing
`define STC_CLK_HZ           10000000
// reading rates in readings per ten seconds (2.5, 20, 100 per second)
`define STC_RATE_SLOW_DHZ    25
`define STC_RATE_MED_DHZ     200
`define STC_RATE_FAST_DHZ    1000
`define STC_PERIOD_CYC(dhz)  ((`STC_CLK_HZ * 10) / (dhz))
`define STC_SETTLE_US        5000
`define STC_SETTLE_CYC       ((`STC_CLK_HZ / 1000000) * `STC_SETTLE_US)

// ==================================================
// event status bit positions
`define STC_EV_OP_DONE       0
`define STC_EV_QUERY_ERR     2
`define STC_EV_DEV_ERR       3
`define STC_EV_EXEC_ERR      4
`define STC_EV_CMD_ERR       5
`define STC_EV_POWER_ON      7
`define STC_EV_USED          8'hbd
`define STC_EV_RESET         8'h80

// ==================================================
// summary status byte bit positions and masks
`define STC_SB_MSG_AVAIL     4
`define STC_SB_EVENT_SUM     5
`define STC_SB_MASTER_SUM    6
`define STC_SVC_USED         8'hbe
`define STC_SVC_STORE        8'hbf
`define STC_MASK_RESET       8'h00
`define STC_VALUE_MAX        16'h00ff

// ==================================================
// trigger types
`define STC_TT_INTERNAL      3'h1
`define STC_TT_PANEL         3'h2
`define STC_TT_PANEL_SETTLE  3'h3
`define STC_TT_REAR          3'h4
`define STC_TT_REAR_SETTLE   3'h5

`endif

/* File: hdl/stc_pkg.sv */
package stc_pkg;

    typedef logic [7:0] stc_byte_t;
    typedef logic [2:0] stc_trig_t;

    typedef enum logic [1:0]
    {
        RATE_SLOW,
        RATE_MEDIUM,
        RATE_FAST
    } stc_rate_t;

    typedef enum logic
    {
        SETTLE_IDLE,
        SETTLE_RUN
    } stc_settle_state_t;

endpackage

/* File: hdl/stc_rate_div.sv */
`timescale 1ns/1ps

// ==================================================
// reading-rate tick divider
module stc_rate_div
    import stc_pkg::*;
#(
    parameter int unsigned SLOW_CYC = 4000000,
    parameter int unsigned MED_CYC  = 500000,
    parameter int unsigned FAST_CYC = 100000
)
(
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    // rate select
    input  wire stc_rate_t rate_i,
    // tick
    output logic           tick_o
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        tick_d;
    logic [31:0] period;

    always_comb
    begin
        case (rate_i)
            RATE_SLOW:   period = SLOW_CYC;
            RATE_MEDIUM: period = MED_CYC;
            default:     period = FAST_CYC;
        endcase
        tick_d = 1'b0;
        cnt_d  = cnt_q + 32'h1;
        // a shortened rate takes effect at once
        if (cnt_q >= period - 32'h1)
        begin
            cnt_d  = 32'h0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q  <= 32'h0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_o <= tick_d;
        end
    end

endmodule

/* File: hdl/stc_settle.sv */
`timescale 1ns/1ps

// ==================================================
// settling delay timer
module stc_settle
    import stc_pkg::*;
#(
    parameter int unsigned DELAY_CYC = 50000
)
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    stc_settle_state_t state_q;
    stc_settle_state_t state_d;
    logic [31:0]       cnt_q;
    logic [31:0]       cnt_d;
    logic              done_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        done_d  = 1'b0;
        case (state_q)
            SETTLE_IDLE:
            begin
                if (start_i)
                begin
                    state_d = SETTLE_RUN;
                    cnt_d   = 32'h0;
                end
            end
            SETTLE_RUN:
            begin
                cnt_d = cnt_q + 32'h1;
                if (cnt_q >= DELAY_CYC - 32'h1)
                begin
                    state_d = SETTLE_IDLE;
                    done_d  = 1'b1;
                end
            end
            default: state_d = SETTLE_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= SETTLE_IDLE;
            cnt_q   <= 32'h0;
            done_o  <= 1'b0;
            busy_o  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            done_o  <= done_d;
            busy_o  <= (state_d == SETTLE_RUN);
        end
    end

endmodule

/* File: verif/stc_top_sva.sv */
`timescale 1ns/1ps

// ==========
// port checker
module stc_top_sva
    import stc_pkg::*;
(
    input wire logic        CLOCK_I, RST_I, CLEAR_STATUS_I, EVENT_MASK_WR_I, SERVICE_MASK_WR_I,
    input wire logic        EVENT_STATUS_RD_I, EVENT_MASK_RD_I, SERVICE_MASK_RD_I, STATUS_BYTE_RD_I,
    input wire logic        SERIAL_POLL_I, OP_COMPLETE_CMD_I, TRIGGER_CMD_I, TRIG_CFG_I, EXEC_ERR_I,
    input wire logic        QUERY_EMPTY_READ_I, QUERY_UNREAD_I, BUFFERS_FULL_I, CAL_INPUT_ERR_I,
    input wire logic        INPUT_OVERFLOW_I, CMD_ERR_I, MSG_PLACED_I,
    input wire logic [15:0] CMD_VALUE_I,
    input wire logic [2:0]  TRIG_CFG_TYPE_I, TRIG_TYPE_O,
    input wire logic [7:0]  RESP_DATA_O, STATUS_BYTE_O, EVENT_STATUS_O,
    input wire logic        RESP_VALID_O, REQ_SERVICE_O, EXT_TRIG_O, SETTLING_O, MEAS_START_O
);
    logic any_rd;
    logic bad_val;
    logic bad_cfg;
    logic any_ev;

    assign any_rd  = EVENT_STATUS_RD_I | EVENT_MASK_RD_I | SERVICE_MASK_RD_I | STATUS_BYTE_RD_I | SERIAL_POLL_I;
    assign bad_val = (EVENT_MASK_WR_I | SERVICE_MASK_WR_I) & (CMD_VALUE_I > 16'h00ff);
    assign bad_cfg = TRIG_CFG_I & (TRIG_CFG_TYPE_I == 3'h0 || TRIG_CFG_TYPE_I > 3'h5);
    assign any_ev  = QUERY_EMPTY_READ_I | QUERY_UNREAD_I | BUFFERS_FULL_I | CAL_INPUT_ERR_I | INPUT_OVERFLOW_I
                   | EXEC_ERR_I | CMD_ERR_I | OP_COMPLETE_CMD_I | bad_val | bad_cfg;

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RST_I);

    // ==========
    // assertions
    chk_resp_after_rd: assert property (any_rd |=> RESP_VALID_O)
        else $error("query not answered");
    chk_event_sticky: assert property (!EVENT_STATUS_RD_I && !CLEAR_STATUS_I
        |=> (EVENT_STATUS_O & $past(EVENT_STATUS_O)) == $past(EVENT_STATUS_O)) else $error("event bit lost");
    chk_read_clears: assert property (EVENT_STATUS_RD_I && !any_ev |=> (EVENT_STATUS_O & 8'hfe) == 8'h00)
        else $error("event read did not clear");
    chk_summary_drop: assert property ((EVENT_STATUS_RD_I || CLEAR_STATUS_I) && !any_ev
        |=> !STATUS_BYTE_O[5]) else $error("event summary stuck");
    chk_query_err: assert property (QUERY_EMPTY_READ_I || QUERY_UNREAD_I || BUFFERS_FULL_I
        |=> EVENT_STATUS_O[2]) else $error("query error missing");
    chk_device_err: assert property (CAL_INPUT_ERR_I || INPUT_OVERFLOW_I |=> EVENT_STATUS_O[3])
        else $error("device error missing");
    chk_exec_err: assert property (EXEC_ERR_I || bad_val || bad_cfg |=> EVENT_STATUS_O[4])
        else $error("execution error missing");
    chk_unused_zero: assert property ((EVENT_STATUS_O & 8'h42) == 8'h00 && (STATUS_BYTE_O & 8'h8f) == 8'h00)
        else $error("unused bit set");
    chk_msg_avail: assert property (MSG_PLACED_I |=> STATUS_BYTE_O[4])
        else $error("message flag missing");
    chk_cfg_apply: assert property (TRIG_CFG_I && !bad_cfg |=> TRIG_TYPE_O == $past(TRIG_CFG_TYPE_I)
        && EXT_TRIG_O == (TRIG_TYPE_O != 3'h1) && SETTLING_O == (TRIG_TYPE_O == 3'h3 || TRIG_TYPE_O == 3'h5))
        else $error("trigger type not applied");
    chk_trg_start: assert property (TRIGGER_CMD_I && EXT_TRIG_O && !SETTLING_O && !TRIG_CFG_I
        |=> MEAS_START_O) else $error("trigger command ignored");
    chk_poll_flag: assert property (SERIAL_POLL_I && !EVENT_STATUS_RD_I && !EVENT_MASK_RD_I
        && !SERVICE_MASK_RD_I && !STATUS_BYTE_RD_I |=> RESP_DATA_O[6] == $past(REQ_SERVICE_O))
        else $error("poll bit wrong");

    cov_settle_start: cover property (SETTLING_O && MEAS_START_O);
    cov_poll_flag: cover property (SERIAL_POLL_I && REQ_SERVICE_O);
    cov_master_sum: cover property (STATUS_BYTE_O[6]);
endmodule

bind stc_top stc_top_sva chk (.*);

/* File: verif/stc_host_model.sv */
`timescale 1ns/1ps

// ==========
// host side: parser strobes
module stc_host_model
    import stc_pkg::*;
(
    // clock and answers
    input  wire logic       clk_i,
    input  wire logic [7:0] resp_data_i,
    input  wire logic       resp_valid_i,
    // strobes and operands
    output logic [19:0]     strobe_o,
    output logic [15:0]     value_o,
    output logic [2:0]      cfg_type_o,
    output logic            first_o,
    output logic            busy_o
);
    initial
    begin
        strobe_o   = 20'h00000;
        value_o    = 16'h0000;
        cfg_type_o = 3'h1;
        first_o    = 1'b0;
        busy_o     = 1'b0;
    end

    // operands scrambled once released
    task automatic pulse(input int idx, input logic [15:0] v = 16'h0000, input logic [2:0] t = 3'h1,
                         input logic f = 1'b0);
        @(negedge clk_i);
        strobe_o[idx] = 1'b1;
        value_o       = v;
        cfg_type_o    = t;
        first_o       = f;
        @(negedge clk_i);
        strobe_o[idx] = 1'b0;
        value_o       = ~v;
        cfg_type_o    = ~t;
        first_o       = ~f;
    endtask

    task automatic ask(input int idx, output logic [7:0] data);
        @(negedge clk_i);
        strobe_o[idx] = 1'b1;
        @(negedge clk_i);
        data          = resp_valid_i ? resp_data_i : 8'hxx;
        strobe_o[idx] = 1'b0;
    endtask

    task automatic done_busy(input int n);
        busy_o = 1'b1;
        pulse(8);
        repeat (n) @(negedge clk_i);
        busy_o = 1'b0;
    endtask
endmodule

/* File: verif/stc_top_bench.sv */
`timescale 1ns/1ps

`define CK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module stc_top_bench
    import stc_pkg::*;
;
    localparam int SLOW = 40, MED = 20, FAST = 10, SETTLE = 5;
    localparam int CLR = 0, EWR = 1, SWR = 2, ERD = 3, EMR = 4, SMR = 5, SBR = 6, POL = 7;
    localparam int TRG = 9, CFG = 10, CERR = 17, MSG = 18, TRM = 19;

    logic        clk, rst, first, busy, remote, key, psel, rear, psvc, resp_v, svc, ext, settling, start;
    logic [19:0] s;
    logic [15:0] val;
    logic [2:0]  cfg_t, ptype, ttype;
    logic [1:0]  rsel;
    logic [7:0]  resp_d, sbyte, evs, d;
    int          err_total, checked, starts, b;

    stc_host_model host (.clk_i(clk), .resp_data_i(resp_d), .resp_valid_i(resp_v), .strobe_o(s),
                         .value_o(val), .cfg_type_o(cfg_t), .first_o(first), .busy_o(busy));

    stc_top #(.SLOW_CYC(SLOW), .MED_CYC(MED), .FAST_CYC(FAST), .SETTLE_CYC(SETTLE)) dut (
        .CLOCK_I(clk), .RST_I(rst), .CLEAR_STATUS_I(s[0]), .CLEAR_FIRST_I(first), .EVENT_MASK_WR_I(s[1]),
        .SERVICE_MASK_WR_I(s[2]), .CMD_VALUE_I(val), .EVENT_STATUS_RD_I(s[3]), .EVENT_MASK_RD_I(s[4]),
        .SERVICE_MASK_RD_I(s[5]), .STATUS_BYTE_RD_I(s[6]), .SERIAL_POLL_I(s[7]), .OP_COMPLETE_CMD_I(s[8]),
        .CMD_BUSY_I(busy), .TRIGGER_CMD_I(s[9]), .TRIG_CFG_I(s[10]), .TRIG_CFG_TYPE_I(cfg_t),
        .QUERY_EMPTY_READ_I(s[11]), .QUERY_UNREAD_I(s[12]), .BUFFERS_FULL_I(s[13]), .CAL_INPUT_ERR_I(s[14]),
        .INPUT_OVERFLOW_I(s[15]), .EXEC_ERR_I(s[16]), .CMD_ERR_I(s[17]), .MSG_PLACED_I(s[18]),
        .TERM_SENT_I(s[19]), .REMOTE_I(remote), .RATE_KEY_I(key), .PANEL_SEL_I(psel), .PANEL_TYPE_I(ptype),
        .REAR_TRIG_I(rear), .PANEL_SERVICE_I(psvc), .RATE_SEL_I(rsel), .RESP_DATA_O(resp_d),
        .RESP_VALID_O(resp_v), .STATUS_BYTE_O(sbyte), .EVENT_STATUS_O(evs), .REQ_SERVICE_O(svc),
        .TRIG_TYPE_O(ttype), .EXT_TRIG_O(ext), .SETTLING_O(settling), .MEAS_START_O(start)
    );
    always @(posedge clk)
        if (start === 1'b1)
            starts++;

    task automatic press;
        @(negedge clk);
        key = 1'b1;
        repeat (2) @(negedge clk);
        key = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic t_events;
        int idx[7] = '{11, 12, 13, 14, 15, 16, 17};
        int bn[7]  = '{2, 2, 2, 3, 3, 4, 5};
        `CK("power on", 8'h80, evs)
        host.ask(ERD, d);
        `CK("first read", 8'h80, d)
        host.pulse(EWR, 16'h00ff);
        foreach (idx[i])
        begin
            host.pulse(idx[i]);
            `CK("summary", 1'b1, sbyte[5])
            host.ask(ERD, d);
            `CK("event read", 8'h01 << bn[i], d)
            `CK("summary drop", 1'b0, sbyte[5])
        end
        host.pulse(EWR, 16'h0010);
        host.pulse(CERR);
        `CK("masked", 1'b0, sbyte[5])
        host.pulse(16);
        `CK("sticky", 8'h30, evs)
        host.pulse(CLR);
        `CK("cleared", 8'h00, evs)
        host.done_busy(3);
        `CK("op pending", 1'b0, evs[0])
        @(negedge clk);
        `CK("op done", 1'b1, evs[0])
        host.ask(ERD, d);
        $display("event test done");
    endtask

    task automatic t_status;
        host.pulse(EWR, 16'h0100);
        `CK("bad value", 1'b1, evs[4])
        host.ask(EMR, d);
        `CK("mask kept", 8'h10, d)
        host.pulse(SWR, 16'hffff);
        host.pulse(CLR);
        host.pulse(SWR, 16'h00ff);
        host.ask(SMR, d);
        `CK("svc mask", 8'hbf, d)
        `CK("master idle", 1'b0, sbyte[6])
        host.pulse(SWR, 16'h0010);
        host.pulse(MSG);
        `CK("msg byte", 8'h50, sbyte)
        host.ask(SBR, d);
        `CK("status query", 8'h50, d)
        `CK("status kept", 8'h50, sbyte)
        host.pulse(TRM);
        `CK("msg sent", 8'h00, sbyte)
        host.ask(POL, d);
        `CK("poll bit", 1'b1, d[6])
        `CK("flag clear", 1'b0, svc)
        host.pulse(MSG);
        host.pulse(CLR, 16'h0000, 3'h1, 1'b0);
        `CK("not first", 1'b1, sbyte[4])
        host.pulse(CLR, 16'h0000, 3'h1, 1'b1);
        `CK("first", 1'b0, sbyte[4])
        host.ask(POL, d);
        psvc = 1'b1;
        @(negedge clk);
        psvc = 1'b0;
        `CK("panel request", 1'b1, svc)
        host.ask(POL, d);
        `CK("panel poll", 1'b0, svc)
        $display("status test done");
    endtask

    task automatic t_trigger;
        int per[3] = '{SLOW, MED, FAST};
        for (int t = 2; t <= 5; t++)
        begin
            host.pulse(CFG, 16'h0000, t[2:0]);
            `CK("type", t[2:0], ttype)
            `CK("settle", t == 3 || t == 5, settling)
            b = starts;
            host.pulse(TRG);
            repeat (SETTLE) @(negedge clk);
            `CK("early", (t == 2 || t == 4) ? 1 : 0, starts - b)
            repeat (4) @(negedge clk);
            `CK("command", 1, starts - b)
        end
        host.pulse(CFG, 16'h0000, 3'h7);
        `CK("bad type", 3'h5, ttype)
        host.pulse(CFG, 16'h0000, 3'h1);
        `CK("internal", 1'b0, ext)
        for (int r = 0; r < 3; r++)
        begin
            rsel = r[1:0];
            b = starts;
            repeat (200) @(negedge clk);
            `CK("rate", 1'b1, starts - b >= 200 / per[r] - 1 && starts - b <= 200 / per[r] + 1)
        end
        host.pulse(CFG, 16'h0000, 3'h2);
        @(negedge clk);
        b = starts;
        repeat (3) press;
        `CK("key", 3, starts - b)
        remote = 1'b1;
        press;
        `CK("remote key", 3, starts - b)
        host.pulse(CFG, 16'h0000, 3'h4);
        `CK("remote ext", 1'b1, ext)
        rear = 1'b1;
        repeat (2 * FAST + 4) @(negedge clk);
        rear = 1'b0;
        `CK("rear", 4, starts - b)
        remote = 1'b0;
        psel = 1'b1;
        @(negedge clk);
        psel = 1'b0;
        `CK("panel type", 3'h1, ttype)
        $display("trigger test done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        {remote, key, psel, rear, psvc} = 5'h00;
        ptype = 3'h1;
        rsel = 2'h2;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_events;
        t_status;
        t_trigger;
        stop_test;
    end

    initial
    begin
        #(5000 * 100);
        err_total++;
        stop_test;
    end
endmodule
